// >>> logic/tpg_cfg.svh
// Purpose: Constants for the three-phase gate control block
// Assumes: 10 MHz i_mclk
// Notes: Times in ns and us, counts derived by expression
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH
// ==========================================
// Clock and timing
`define TPG_CLK_PERIOD_NS 100
`define TPG_DT_MIN_NS 50
`define TPG_DT_MAX_NS 500
// Least time rounds up, never below one cycle
`define TPG_DT_MIN_CYC ((`TPG_DT_MIN_NS + `TPG_CLK_PERIOD_NS - 1) / `TPG_CLK_PERIOD_NS)
`define TPG_DT_MAX_CYC ((`TPG_DT_MAX_NS + `TPG_CLK_PERIOD_NS - 1) / `TPG_CLK_PERIOD_NS)
`define TPG_WARN_US 64
// Longest time rounds down
`define TPG_WARN_CYC ((`TPG_WARN_US * 1000) / `TPG_CLK_PERIOD_NS)
// ==========================================
// Field widths and phase count
`define TPG_DT_W 4
`define TPG_WARN_W 10
`define TPG_LVL_W 8
`define TPG_PHASES 3
`endif

// >>> logic/tpg_pkg.sv
// Purpose: Types for the three-phase gate control block
// Assumes: Constants come from tpg_cfg.svh
// Notes: Types only
`include "tpg_cfg.svh"
package tpg_pkg;
  // ==========================================
  // Per-phase gate state
  typedef enum logic [2:0] {
    TPG_OFF,
    TPG_DEAD_TO_HI,
    TPG_HI,
    TPG_DEAD_TO_LO,
    TPG_LO
  } tpg_gate_state_t;
  typedef logic [`TPG_DT_W-1:0] tpg_dt_t;
  typedef logic [`TPG_LVL_W-1:0] tpg_lvl_t;
endpackage : tpg_pkg

// >>> logic/tpg_phase.sv
// Purpose: One half-bridge: command decode, dead time, interlock, overcurrent
// Assumes: Inputs already synchronised to i_mclk
// Notes: Gates are registered
`timescale 1ns/1ps
`include "tpg_cfg.svh"
module tpg_phase (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_three_input_mode,
  input wire logic i_high_side_command,
  input wire logic i_low_side_command,
  input wire tpg_pkg::tpg_dt_t i_dead_cycles,
  input wire logic i_enable,
  input wire logic i_force_off,
  input wire logic i_latched_mode,
  input wire logic i_clear_latch,
  input wire logic i_oc_high,
  input wire logic i_oc_low,
  output logic o_high_side_gate,
  output logic o_low_side_gate,
  output logic o_oc_event,
  output logic o_latched,
  output logic o_new_cycle
);
  import tpg_pkg::*;
  tpg_gate_state_t state;
  tpg_gate_state_t next_state;
  tpg_dt_t dead_cnt;
  logic want_hi;
  logic want_lo;
  logic cmd_hi_q;
  logic cmd_lo_q;
  logic hi_blocked;
  logic lo_blocked;
  logic latched;
  logic trip_hi;
  logic trip_lo;
  logic gate_allowed;

  // ==========================================
  // Command decode
  always_comb begin
    if (i_three_input_mode) begin
      want_hi = i_high_side_command;
      want_lo = !i_high_side_command;
    end else begin
      want_hi = i_high_side_command && !i_low_side_command;
      want_lo = i_low_side_command && !i_high_side_command;
    end
  end

  // Rising command edge marks a new PWM cycle for that switch
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cmd_hi_q <= 1'b0;
      cmd_lo_q <= 1'b0;
    end else begin
      cmd_hi_q <= want_hi;
      cmd_lo_q <= want_lo;
    end
  end
  assign o_new_cycle = (want_hi && !cmd_hi_q) || (want_lo && !cmd_lo_q);

  // ==========================================
  // Overcurrent sensing, only while the switch is on
  assign trip_hi = o_high_side_gate && i_oc_high;
  assign trip_lo = o_low_side_gate && i_oc_low;
  assign o_oc_event = trip_hi || trip_lo;

  // Cycle-by-cycle block until the command cycles again
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hi_blocked <= 1'b0;
      lo_blocked <= 1'b0;
    end else begin
      if (trip_hi && !i_latched_mode) hi_blocked <= 1'b1;
      else if (want_hi && !cmd_hi_q) hi_blocked <= 1'b0;
      if (trip_lo && !i_latched_mode) lo_blocked <= 1'b1;
      else if (want_lo && !cmd_lo_q) lo_blocked <= 1'b0;
    end
  end

  // Latched shutdown of the whole half-bridge; set wins over clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) latched <= 1'b0;
    else if (o_oc_event && i_latched_mode) latched <= 1'b1;
    else if (i_clear_latch) latched <= 1'b0;
  end
  assign o_latched = latched;

  assign gate_allowed = i_enable && !i_force_off && !latched && !(o_oc_event && i_latched_mode);

  // ==========================================
  // Gate sequencing: off, then dead time, then on
  always_comb begin
    next_state = state;
    if (!gate_allowed) next_state = TPG_OFF;
    else unique case (state)
      TPG_OFF: begin
        if (want_hi && !hi_blocked) next_state = TPG_DEAD_TO_HI;
        else if (want_lo && !lo_blocked) next_state = TPG_DEAD_TO_LO;
      end
      TPG_DEAD_TO_HI: begin
        if (!(want_hi && !hi_blocked)) next_state = TPG_OFF;
        else if (dead_cnt == '0) next_state = TPG_HI;
      end
      TPG_DEAD_TO_LO: begin
        if (!(want_lo && !lo_blocked)) next_state = TPG_OFF;
        else if (dead_cnt == '0) next_state = TPG_LO;
      end
      TPG_HI: if (!want_hi || trip_hi) next_state = TPG_OFF;
      TPG_LO: if (!want_lo || trip_lo) next_state = TPG_OFF;
      default: next_state = TPG_OFF;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) state <= TPG_OFF;
    else state <= next_state;
  end

  // Dead counter starts at off; time spent off already counts toward it
  always_ff @(posedge i_mclk) begin
    if (i_rst) dead_cnt <= '0;
    else if (state == TPG_HI || state == TPG_LO || !gate_allowed) dead_cnt <= i_dead_cycles - 4'h1;
    else if (dead_cnt != '0) dead_cnt <= dead_cnt - 4'h1;
  end

  // Registered gates; only one can be on by construction
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_high_side_gate <= 1'b0;
      o_low_side_gate <= 1'b0;
    end else begin
      o_high_side_gate <= (next_state == TPG_HI);
      o_low_side_gate <= (next_state == TPG_LO);
    end
  end
endmodule : tpg_phase

// >>> logic/tpg_top.sv
// Purpose: Three-phase half-bridge gate control with protection
// Assumes: Pins are asynchronous; sensed drain-source voltages arrive as 8-bit levels
// Notes: Analog sense, amplifier and regulator are outside this block
// Function
// - The mode input picks 6 or 3 input control, and in 6 input mode equal commands turn both gates off.
// - Dead time is at least 50 ns with the setting at zero, and adjustable up to 500 ns.
// - A phase never turns one gate on before the other is off.
// - With enable low or the device fault input high all gates are held off.
// - Overcurrent is judged only while that switch's gate is driven on.
// - Overcurrent is flagged when sensed drain-source voltage exceeds the trip level.
// - A mode input picks cycle-by-cycle limiting or latched shutdown.
// - Calibration shorts the amplifier inputs and disconnects the load, at any time.
// - In cycle-by-cycle mode the tripped switch stays off until the next cycle, warning low at most 64 us.
// - In latched mode both switches of the bridge turn off and the fault stays low until an enable pulse.
// - Dead time is a minimum gap from turn-off to complementary turn-on, not an added delay.
`timescale 1ns/1ps
`include "tpg_cfg.svh"
module tpg_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [2:0] i_high_side_command,
  input wire logic [2:0] i_low_side_command,
  input wire logic i_three_input_mode,
  input wire logic i_overcurrent_mode_select,
  input wire logic i_gate_enable,
  input wire logic i_device_fault,
  input wire tpg_pkg::tpg_dt_t i_dead_time_setting,
  input wire tpg_pkg::tpg_lvl_t i_trip_level_input,
  input wire tpg_pkg::tpg_lvl_t i_vds_high [3],
  input wire tpg_pkg::tpg_lvl_t i_vds_low [3],
  input wire logic i_offset_calibration_enable,
  output logic [2:0] o_high_side_gate,
  output logic [2:0] o_low_side_gate,
  output logic o_shutdown_flag_n,
  output logic o_warning_flag_n,
  output logic o_amp_input_short,
  output logic o_amp_load_disconnect
);
  import tpg_pkg::*;
  logic [2:0] hi_s1;
  logic [2:0] hi_s2;
  logic [2:0] lo_s1;
  logic [2:0] lo_s2;
  logic [4:0] ctl_s1;
  logic [4:0] ctl_s2;
  logic en_q;
  logic clear_pulse;
  logic [2:0] oc_ev;
  logic [2:0] latched;
  logic [2:0] new_cycle;
  logic [2:0] warn_pending;
  logic [`TPG_WARN_W-1:0] warn_cnt;
  tpg_dt_t dead_cycles;
  tpg_dt_t dt_clip;

  // ==========================================
  // Input synchronisers; first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hi_s1 <= 3'h0;
      hi_s2 <= 3'h0;
      lo_s1 <= 3'h0;
      lo_s2 <= 3'h0;
      ctl_s1 <= 5'h00;
      ctl_s2 <= 5'h00;
    end else begin
      hi_s1 <= i_high_side_command;
      hi_s2 <= hi_s1;
      lo_s1 <= i_low_side_command;
      lo_s2 <= lo_s1;
      ctl_s1 <= {i_offset_calibration_enable, i_device_fault, i_gate_enable, i_overcurrent_mode_select,
                 i_three_input_mode};
      ctl_s2 <= ctl_s1;
    end
  end

  // Enable falling edge clears latched faults
  always_ff @(posedge i_mclk) begin
    if (i_rst) en_q <= 1'b0;
    else en_q <= ctl_s2[2];
  end
  assign clear_pulse = !ctl_s2[2] && en_q;

  // ==========================================
  // Dead time: setting in clock cycles, clipped to the adjustable range
  always_comb begin
    dt_clip = i_dead_time_setting;
    if (dt_clip < 4'(`TPG_DT_MIN_CYC)) dt_clip = 4'(`TPG_DT_MIN_CYC);
    if (dt_clip > 4'(`TPG_DT_MAX_CYC)) dt_clip = 4'(`TPG_DT_MAX_CYC);
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) dead_cycles <= 4'(`TPG_DT_MIN_CYC);
    else dead_cycles <= dt_clip;
  end

  // ==========================================
  // Per-phase half-bridges
  genvar g;
  generate
    for (g = 0; g < `TPG_PHASES; g++) begin : g_phase
      tpg_phase u_phase (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_three_input_mode(ctl_s2[0]),
        .i_high_side_command(hi_s2[g]),
        .i_low_side_command(lo_s2[g]),
        .i_dead_cycles(dead_cycles),
        .i_enable(ctl_s2[2]),
        .i_force_off(ctl_s2[3]),
        .i_latched_mode(ctl_s2[1]),
        .i_clear_latch(clear_pulse),
        .i_oc_high(i_vds_high[g] > i_trip_level_input),
        .i_oc_low(i_vds_low[g] > i_trip_level_input),
        .o_high_side_gate(o_high_side_gate[g]),
        .o_low_side_gate(o_low_side_gate[g]),
        .o_oc_event(oc_ev[g]),
        .o_latched(latched[g]),
        .o_new_cycle(new_cycle[g])
      );
    end
  endgenerate

  // ==========================================
  // Warning: held low per event for up to 64 us or until the tripped phase cycles
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      warn_pending <= 3'h0;
      warn_cnt <= '0;
    end else begin
      warn_pending <= (warn_pending & ~new_cycle) | (ctl_s2[1] ? 3'h0 : oc_ev);
      if (|oc_ev && !ctl_s2[1]) warn_cnt <= `TPG_WARN_W'(`TPG_WARN_CYC);
      else if (warn_cnt != '0) warn_cnt <= warn_cnt - 1'b1;
    end
  end

  // Flags registered; fault follows latched trips and external fault
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_warning_flag_n <= 1'b1;
      o_shutdown_flag_n <= 1'b1;
    end else begin
      o_warning_flag_n <= !((|warn_pending && warn_cnt > `TPG_WARN_W'(1)) || (|oc_ev && !ctl_s2[1]));
      o_shutdown_flag_n <= !(|latched || ctl_s2[3]);
    end
  end

  // ==========================================
  // Calibration switches; allowed regardless of gate activity
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_amp_input_short <= 1'b0;
      o_amp_load_disconnect <= 1'b0;
    end else begin
      o_amp_input_short <= ctl_s2[4];
      o_amp_load_disconnect <= ctl_s2[4];
    end
  end
endmodule : tpg_top

// >>> verif/tpg_top_properties.sv
// Purpose: Port checks on tpg_top
// Assumes: Two sync flops on every command and control pin
// Notes: Windows allow the sync latency
`timescale 1ns/1ps
module tpg_top_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [2:0] i_high_side_command,
  input wire logic i_three_input_mode,
  input wire logic i_gate_enable,
  input wire logic i_device_fault,
  input wire logic i_offset_calibration_enable,
  input wire logic [2:0] o_high_side_gate,
  input wire logic [2:0] o_low_side_gate,
  input wire logic o_shutdown_flag_n,
  input wire logic o_warning_flag_n,
  input wire logic o_amp_input_short,
  input wire logic o_amp_load_disconnect
);
  // ==========================================
  // Helpers
  logic [9:0] warn_len;
  wire logic any_on = |{o_high_side_gate, o_low_side_gate};
  // A latched trip stops its own bridge only, so at least one bridge is dark
  wire logic any_bridge_off = (~(o_high_side_gate | o_low_side_gate)) != 3'h0;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Length of the present warning pulse
  always_ff @(posedge i_mclk) begin
    if (i_rst || o_warning_flag_n)
      warn_len <= 10'h000;
    else
      warn_len <= warn_len + 10'h001;
  end
  sequence en_low_s; !i_gate_enable [*4]; endsequence
  sequence fault_s; i_device_fault [*5]; endsequence
  sequence hi3_s; (i_three_input_mode && i_high_side_command[0]) [*4]; endsequence
  sequence cal_s; i_offset_calibration_enable [*4]; endsequence
  // ==========================================
  // Assertions
  no_shoot_a: assert property ((o_high_side_gate & o_low_side_gate) == 3'h0)
    else $error("both gates on");
  en_off_a: assert property (en_low_s |-> {o_high_side_gate, o_low_side_gate} == 6'h00)
    else $error("gate on while disabled");
  fault_off_a: assert property (fault_s |-> !any_on && !o_shutdown_flag_n)
    else $error("gate on under fault");
  hi3_low_a: assert property (hi3_s |-> !o_low_side_gate[0])
    else $error("low gate on in 3-input high");
  cal_on_a: assert property (cal_s |-> o_amp_input_short && o_amp_load_disconnect)
    else $error("calibration not applied");
  warn_len_a: assert property (warn_len < 10'h281)
    else $error("warning too long");
  oc_on_a: assert property ($fell(o_warning_flag_n) |-> $past(any_on) || $past(any_on, 2))
    else $error("trip on an off switch");
  latch_off_a: assert property (!o_shutdown_flag_n && $past(!o_shutdown_flag_n) |-> any_bridge_off)
    else $error("gate on while latched");
endmodule : tpg_top_properties

bind tpg_top tpg_top_properties u_tpg_top_properties (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_high_side_command(i_high_side_command), .i_three_input_mode(i_three_input_mode),
  .i_gate_enable(i_gate_enable), .i_device_fault(i_device_fault),
  .i_offset_calibration_enable(i_offset_calibration_enable), .o_high_side_gate(o_high_side_gate),
  .o_low_side_gate(o_low_side_gate), .o_shutdown_flag_n(o_shutdown_flag_n),
  .o_warning_flag_n(o_warning_flag_n), .o_amp_input_short(o_amp_input_short),
  .o_amp_load_disconnect(o_amp_load_disconnect));

// >>> verif/tpg_mcu_model.sv
// Purpose: Controller model for the phase commands
// Assumes: Commands change just after the edge
// Notes: Random PWM only while i_run is high
`timescale 1ns/1ps
module tpg_mcu_model (
  input wire logic i_mclk,
  input wire logic i_run,
  input wire logic [2:0] i_set_high,
  input wire logic [2:0] i_set_low,
  output logic [2:0] o_high_side_command,
  output logic [2:0] o_low_side_command
);
  // ==========================================
  // Command generation
  logic busy;
  initial begin
    o_high_side_command = 3'h0;
    o_low_side_command = 3'h0;
  end
  // Idle holds set values; random hold time gives fast and slow edges
  always @(posedge i_mclk) begin
    for (int k = 0; k < 3; k++) begin
      busy = o_high_side_command[k] | o_low_side_command[k];
      if (!i_run) begin
        o_high_side_command[k] <= i_set_high[k];
        o_low_side_command[k] <= i_set_low[k];
      end else if ($urandom_range(3) == 0) begin
        o_high_side_command[k] <= !busy && $urandom_range(1) == 1;
        o_low_side_command[k] <= !busy && $urandom_range(1) == 0;
      end
    end
  end
endmodule : tpg_mcu_model

// >>> verif/tpg_top_tb.sv
// Purpose: Self-checking bench for tpg_top
// Assumes: Dead time setting counts clock cycles
// Notes: Random PWM comes from the controller model
`timescale 1ns/1ps
`include "tpg_cfg.svh"
`define CHK(n, e, s) begin #1; compares++; if ((e) !== (s)) begin failures++; $display("Error %s exp %h got %h", n, e, s); end end
module tpg_top_tb;
  import tpg_pkg::*;
  // ==========================================
  // Stimulus and observation
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic m3 = 1'b0, ocm = 1'b0, en = 1'b0, flt = 1'b0, cal = 1'b0, run = 1'b0;
  logic [2:0] sh = 3'h0, sl = 3'h0, hc, lc, gh, gl;
  logic fl_n, wr_n, a_sh, a_dc;
  tpg_dt_t dts = 4'h0;
  tpg_lvl_t trip = 8'hFF;
  tpg_lvl_t vh [3] = '{3{8'h00}};
  tpg_lvl_t vl [3] = '{3{8'h00}};
  int failures = 0, compares = 0, n;
  always #50 i_mclk = ~i_mclk;
  tpg_mcu_model u_tpg_mcu_model (.i_mclk(i_mclk), .i_run(run), .i_set_high(sh), .i_set_low(sl),
    .o_high_side_command(hc), .o_low_side_command(lc));
  tpg_top u_tpg_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_high_side_command(hc), .i_low_side_command(lc),
    .i_three_input_mode(m3), .i_overcurrent_mode_select(ocm), .i_gate_enable(en), .i_device_fault(flt),
    .i_dead_time_setting(dts), .i_trip_level_input(trip), .i_vds_high(vh), .i_vds_low(vl),
    .i_offset_calibration_enable(cal), .o_high_side_gate(gh), .o_low_side_gate(gl), .o_shutdown_flag_n(fl_n),
    .o_warning_flag_n(wr_n), .o_amp_input_short(a_sh), .o_amp_load_disconnect(a_dc));
  // ==========================================
  // Expectations and helpers
  function automatic logic [5:0] exp_gates(input logic m, input logic h, input logic l);
    return m ? {{3{h}}, {3{!h}}} : {{3{h & !l}}, {3{l & !h}}};
  endfunction : exp_gates
  // Setting is clipped to the 50 ns..500 ns range, rounded up
  function automatic int exp_dead(input int s);
    return s < `TPG_DT_MIN_CYC ? `TPG_DT_MIN_CYC : (s > `TPG_DT_MAX_CYC ? `TPG_DT_MAX_CYC : s);
  endfunction : exp_dead
  task automatic tick(input int c);
    repeat (c) @(posedge i_mclk);
  endtask : tick
  task automatic report_and_stop();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Bounded wait for a gate pattern, cycles left in n
  task automatic wait_gate(input logic [5:0] want);
    n = 0;
    while ({gh, gl} !== want) begin
      @(posedge i_mclk);
      #1;
      n++;
      if (n > 900) begin
        failures++;
        report_and_stop();
      end
    end
  endtask : wait_gate
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hFEDE));
    tick(3);
    i_rst <= 1'b0;
    tick(1);
    `CHK("reset", 9'h006, {gh, gl, fl_n, wr_n, a_sh})
    en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      m3 <= i[2];
      sh <= {3{i[1]}};
      sl <= {3{i[0]}};
      tick(14);
      `CHK("decode", exp_gates(i[2], i[1], i[0]), {gh, gl})
    end
    // Direct swap: clip low, mid and clip high settings
    for (int j = 0; j < 3; j++) begin
      tick(1);
      m3 <= 1'b0;
      dts <= 4'(j * 4);
      sh <= 3'h7;
      sl <= 3'h0;
      tick(14);
      sh <= 3'h0;
      sl <= 3'h7;
      wait_gate(6'h00);
      wait_gate(6'h07);
      `CHK("dead gap", 1'b1, n >= exp_dead(j * 4) && n <= exp_dead(j * 4) + 2)
    end
    // Long controller gap must not get extra delay
    tick(1);
    sl <= 3'h0;
    tick(14);
    sl <= 3'h7;
    wait_gate(6'h07);
    // Model step, two sync flops, off to dead state, dead to on: five cycles in all
    `CHK("no added delay", 1'b1, n <= 5)
    tick(1);
    en <= 1'b0;
    tick(5);
    `CHK("disabled", 6'h00, {gh, gl})
    tick(1);
    en <= 1'b1;
    flt <= 1'b1;
    tick(6);
    `CHK("fault", 7'h00, {gh, gl, fl_n})
    tick(1);
    flt <= 1'b0;
    en <= 1'b0;
    tick(3);
    en <= 1'b1;
    trip <= 8'($urandom_range(200)) + 8'h10;
    sh <= 3'h7;
    sl <= 3'h0;
    tick(14);
    vl[0] <= 8'hFF;
    vh[0] <= trip;
    tick(5);
    `CHK("off switch, equal level", 4'hF, {gh, wr_n})
    tick(1);
    vl[0] <= 8'h00;
    vh[0] <= trip + 8'h01;
    tick(4);
    `CHK("trip", 4'hC, {gh, wr_n})
    vh[0] <= 8'h00;
    for (n = 0; n < 700 && wr_n !== 1'b1; n++) @(negedge i_mclk);
    `CHK("warning length", 1'b1, n <= `TPG_WARN_CYC)
    `CHK("stays off", 3'h6, gh)
    tick(1);
    sh <= 3'h6;
    tick(4);
    sh <= 3'h7;
    ocm <= 1'b1;
    tick(14);
    `CHK("next cycle", 4'hF, {gh, wr_n})
    vh[1] <= 8'hFF;
    tick(6);
    // Only the tripped bridge stops; phases 0 and 2 keep their high gates
    `CHK("latched", 7'h50, {gh, gl, fl_n})
    tick(1);
    vh[1] <= 8'h00;
    en <= 1'b0;
    tick(3);
    en <= 1'b1;
    tick(14);
    `CHK("latch cleared", 7'h71, {gh, gl, fl_n})
    // Calibration while switching at random; sense never exceeds the trip level
    tick(1);
    trip <= 8'hFF;
    cal <= 1'b1;
    run <= 1'b1;
    repeat (400) begin
      tick(1);
      vh[$urandom_range(2)] <= 8'($urandom);
      m3 <= ($urandom_range(15) == 0) ? ~m3 : m3;
    end
    `CHK("calibration", 2'h3, {a_sh, a_dc})
    tick(1);
    i_rst <= 1'b1;
    tick(2);
    i_rst <= 1'b0;
    tick(1);
    `CHK("second reset", 8'h00, {gh, gl, a_sh, a_dc})
    report_and_stop();
  end
endmodule : tpg_top_tb
